// ### dv/wdtc_top_test.sv
// Self-checking bench for the watchdog timer block.
// Fast dividers: one 100 ms tick every 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module wdtc_top_test;
	import wdtc_pkg::*;
	logic ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, sel = 0, pri = 0;
	logic en = 1;
	logic [7:0] sfr_addr = 8'h00, rdata, v;
	wdtc_byte_t sfr_wdata = 8'h00;
	logic sys_rst, irq, irq_hi, running;
	int fail_count = 0, n_tests = 0, n_irq = 0, n_rst = 0;
	wdtc_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(en),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .ms_divider(16'h0001),
		.hundred_ms_divider(8'h03), .expiry_reset_select(sel),
		.watchdog_irq_priority(pri), .sfr_rdata(rdata),
		.wdt_sys_reset(sys_rst), .wdt_irq(irq), .wdt_irq_high(irq_hi),
		.wdt_running(running));
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (irq === 1'b1)
			n_irq <= n_irq + 1;
		if (sys_rst === 1'b1)
			n_rst <= n_rst + 1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic wreg(input logic [7:0] a, d);
		@(posedge ref_clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge ref_clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 v = rdata;
	endtask : rreg
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rreg(8'hff);
		check(v, 8'h00);
		wreg(8'hff, 8'h1f);
		rreg(8'hff);
		check(v, 8'h1f);
		rreg(8'hfe);
		check(v, 8'h00);
	endtask : t_regs
	task automatic t_arm();
		wreg(8'hff, 8'h80);
		#1 check(8'(running), 8'h00);
		wreg(8'hff, 8'h02);
		@(posedge ref_clk);
		#1 check(8'(running), 8'h01);
	endtask : t_arm
	// Arm, then restart: window 27..35 covers tick phase and two-cycle lag
	task automatic t_expiry(input logic s);
		int n0, r0, k;
		sel <= s;
		wreg(8'hff, 8'h80);
		wreg(8'hff, 8'h22);
		wreg(8'hff, 8'h02);
		n0 = n_irq;
		r0 = n_rst;
		for (k = 1; k < 60 && n_irq + n_rst == n0 + r0; k++)
			@(posedge ref_clk);
		check(8'(k >= 27 && k <= 35), 8'h01);
		check(8'(n_rst - r0), 8'(s));
		check(8'(n_irq - n0), 8'(!s));
	endtask : t_expiry
	task automatic t_restart();
		int n0;
		n0 = n_irq + n_rst;
		for (int k = 0; k < 6; k++) begin
			repeat (8) @(posedge ref_clk);
			wreg(8'hff, 8'h22);
			wreg(8'hff, 8'h02);
		end
		check(8'(n_irq + n_rst - n0), 8'h00);
		wreg(8'hff, 8'h40);
		wreg(8'hff, 8'h02);
		n0 = n_irq + n_rst;
		repeat (60) @(posedge ref_clk);
		check(8'(n_irq + n_rst - n0), 8'h00);
		#1 check(8'(running), 8'h00);
		// Frozen clock enable must swallow the write
		en <= 1'b0;
		wreg(8'hff, 8'h05);
		en <= 1'b1;
		rreg(8'hff);
		check(v, 8'h02);
		pri <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 check(8'(irq_hi), 8'h01);
	endtask : t_restart
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_arm();
		t_expiry(1'b0);
		t_expiry(1'b1);
		t_restart();
		report_and_stop();
	end
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule : wdtc_top_test
`default_nettype wire

// ### hw/wdtc_map.svh
// Register offset, field positions and reset values of the watchdog block.
// Assumes an 8-bit special function register port addressed by byte.
`ifndef WDTC_MAP_SVH
`define WDTC_MAP_SVH
`define WDTC_CTRL_ADDR 8'hff
`define WDTC_CTRL_RST 8'h00
`define WDTC_ARM_BIT 7
`define WDTC_DISARM_BIT 6
`define WDTC_RESTART_BIT 5
`define WDTC_CNT_MSB 4
`define WDTC_CNT_LSB 0
`define WDTC_HMS_RST 8'h63
`define WDTC_MS_RST 16'h0f9f
`endif

// ### hw/wdtc_pkg.sv
// Types shared by the watchdog block.
// Assumes the map header for offsets and reset values.
package wdtc_pkg;
	typedef logic [7:0] wdtc_byte_t;
	typedef enum logic [0:0] {
		WDTC_IDLE = 1'b0,
		WDTC_RUN = 1'b1
	} wdtc_state_t;
endpackage : wdtc_pkg

// ### hw/wdtc_top.sv
// Watchdog timer with its own 1 ms and 100 ms timebase dividers.
// Assumes a single-cycle special function register write/read port.
// Notes on behaviour
// (R1) Arm bit written one then zero sets the counting enable, unless disarm fires in the same write.
// (R2) Disarm bit written one then zero clears the counting enable.
// (R3) Restart bit written one then zero restarts the counter from zero.
// (R4) Expiry after count+1 to count+2 hundred-millisecond ticks.
// (R5) Expiry-reset select set: expiry gives a system reset pulse.
// (R6) Expiry-reset select clear: expiry gives a watchdog interrupt.
// (R7) Five-bit period field is readable and writable.
// (R8) Tick is the 1 ms clock divided by divider value plus one.
// (R9) Priority bit marks the watchdog interrupt low or high priority.
// (R10) Action fires on a zero write following a one write to the bit.
`include "wdtc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdtc_top #(
	parameter int CNT_W = 5
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire wdtc_pkg::wdtc_byte_t sfr_wdata,
	input wire logic [15:0] ms_divider,
	input wire logic [7:0] hundred_ms_divider,
	input wire logic expiry_reset_select,
	input wire logic watchdog_irq_priority,
	output logic [7:0] sfr_rdata,
	output logic wdt_sys_reset,
	output logic wdt_irq,
	output logic wdt_irq_high,
	output logic wdt_running
);
	import wdtc_pkg::*;

	////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] rdata_q, rdata_d;
	wdtc_state_t state_q, state_d;
	logic [15:0] ms_cnt_q, ms_cnt_d;
	logic [7:0] hms_cnt_q, hms_cnt_d;
	logic [CNT_W:0] wd_cnt_q, wd_cnt_d;
	logic rst_q, rst_d, irq_q, irq_d, prio_q, prio_d;
	logic ctrl_wr, arm_ev, disarm_ev, restart_ev, tick, expire;

	assign ctrl_wr = sfr_wr && (sfr_addr == `WDTC_CTRL_ADDR);
	// Falling write edge on a previously set bit
	assign arm_ev = ctrl_wr && ctrl_q[`WDTC_ARM_BIT]
		&& !sfr_wdata[`WDTC_ARM_BIT]; // R10 R1
	assign disarm_ev = ctrl_wr && ctrl_q[`WDTC_DISARM_BIT]
		&& !sfr_wdata[`WDTC_DISARM_BIT]; // R10 R2
	assign restart_ev = ctrl_wr && ctrl_q[`WDTC_RESTART_BIT]
		&& !sfr_wdata[`WDTC_RESTART_BIT]; // R10 R3
	assign tick = (ms_cnt_q == ms_divider)
		&& (hms_cnt_q == hundred_ms_divider); // R8
	// Tick phase is free running, hence the one-tick uncertainty
	assign expire = (state_q == WDTC_RUN) && tick && !restart_ev
		&& (wd_cnt_q == {1'b0, ctrl_q[`WDTC_CNT_MSB:`WDTC_CNT_LSB]} + 1'b1); // R4

	////////////////////////////////////////////////////////////////
	always_comb begin
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		if (ctrl_wr) begin
			ctrl_d = sfr_wdata; // R7
		end
		if (sfr_rd && (sfr_addr == `WDTC_CTRL_ADDR)) begin
			rdata_d = ctrl_q;
		end else if (sfr_rd) begin
			rdata_d = 8'h00;
		end
	end

	always_comb begin
		ms_cnt_d = ms_cnt_q + 16'h0001;
		hms_cnt_d = hms_cnt_q;
		if (ms_cnt_q == ms_divider) begin
			ms_cnt_d = 16'h0000;
			hms_cnt_d = hms_cnt_q + 8'h01;
			if (hms_cnt_q == hundred_ms_divider) begin
				hms_cnt_d = 8'h00; // R8
			end
		end
	end

	always_comb begin
		state_d = state_q;
		wd_cnt_d = wd_cnt_q;
		if (disarm_ev) begin
			state_d = WDTC_IDLE; // R2
		end else if (arm_ev) begin
			state_d = WDTC_RUN; // R1
		end
		if (restart_ev || expire) begin
			wd_cnt_d = '0; // R3
		end else if ((state_q == WDTC_RUN) && tick) begin
			wd_cnt_d = wd_cnt_q + 1'b1; // R4
		end
		rst_d = expire && expiry_reset_select; // R5
		irq_d = expire && !expiry_reset_select; // R6
		prio_d = watchdog_irq_priority; // R9
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `WDTC_CTRL_RST;
			rdata_q <= 8'h00;
			state_q <= WDTC_IDLE;
			ms_cnt_q <= 16'h0000;
			hms_cnt_q <= 8'h00;
			wd_cnt_q <= '0;
			rst_q <= 1'b0;
			irq_q <= 1'b0;
			prio_q <= 1'b0;
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			state_q <= state_d;
			ms_cnt_q <= ms_cnt_d;
			hms_cnt_q <= hms_cnt_d;
			wd_cnt_q <= wd_cnt_d;
			rst_q <= rst_d;
			irq_q <= irq_d;
			prio_q <= prio_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign wdt_sys_reset = rst_q;
	assign wdt_irq = irq_q;
	assign wdt_irq_high = prio_q;
	assign wdt_running = (state_q == WDTC_RUN);

	////////////////////////////////////////////////////////////////
	sequence s_arm_pair;
		ctrl_wr && sfr_wdata[`WDTC_ARM_BIT] ##1 clk_en && arm_ev;
	endsequence

	chk_arm_sets_run: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && arm_ev && !disarm_ev |=> state_q == WDTC_RUN) // R1
		else $error("arm sequence did not start counting");
	chk_disarm_stops: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && disarm_ev |=> state_q == WDTC_IDLE) // R2
		else $error("disarm sequence did not stop counting");
	chk_restart_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && restart_ev |=> wd_cnt_q == '0) // R3
		else $error("restart did not clear counter");
	chk_expiry_count: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && expire |-> wd_cnt_q
			== {1'b0, ctrl_q[`WDTC_CNT_MSB:`WDTC_CNT_LSB]} + 1'b1) // R4
		else $error("expiry at wrong tick count");
	chk_reset_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && expire && expiry_reset_select |=> wdt_sys_reset && !wdt_irq) // R5
		else $error("expiry did not give system reset");
	chk_irq_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && expire && !expiry_reset_select |=> wdt_irq && !wdt_sys_reset) // R6
		else $error("expiry did not give interrupt");
	chk_period_rw: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && ctrl_wr |=> ctrl_q[`WDTC_CNT_MSB:`WDTC_CNT_LSB]
			== $past(sfr_wdata[`WDTC_CNT_MSB:`WDTC_CNT_LSB])) // R7
		else $error("period field not stored");
	chk_tick_div: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en && tick |=> ms_cnt_q == 16'h0000 && hms_cnt_q == 8'h00) // R8
		else $error("tick off the 1 ms boundary");
	chk_prio_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
		clk_en |=> wdt_irq_high == $past(watchdog_irq_priority)) // R9
		else $error("priority output wrong");
	chk_pair_only: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_arm_pair |-> ##1 (state_q == WDTC_RUN || $past(disarm_ev))) // R10
		else $error("one-zero pair not honoured");
endmodule : wdtc_top
`default_nettype wire
